//--- logic/sad_pkg.sv
// Constants and carrier types for the system address decoder
package sad_pkg;

    // Number of decoded target windows
    localparam int N_TGT = 39;
    // Index of each named window
    localparam int TGT_FLASH      = 0;
    localparam int TGT_SRAM       = 1;
    localparam int TGT_TRACE_UNIT = 34;
    localparam int TGT_IRQ_CTRL   = 37;

    // Alias regions and the spaces they fold onto
    localparam logic [31:0] SRAM_BASE       = 32'h2000_0000;
    localparam logic [31:0] SRAM_ALIAS_LO   = 32'h2200_0000;
    localparam logic [31:0] SRAM_ALIAS_HI   = 32'h23ff_ffff;
    localparam logic [31:0] PERI_BASE       = 32'h4000_0000;
    localparam logic [31:0] PERI_ALIAS_LO   = 32'h4200_0000;
    localparam logic [31:0] PERI_ALIAS_HI   = 32'h43ff_ffff;
    localparam logic [31:0] ALIAS_OFF_MASK  = 32'h01ff_ffff;

    // Window bases; sizes are 2**TGT_LOG bytes
    localparam logic [31:0] TGT_BASE [N_TGT] = '{
        32'h0000_0000, 32'h2000_0000,
        32'h4000_0000, 32'h4000_4000, 32'h4000_5000, 32'h4000_6000,
        32'h4000_7000, 32'h4000_8000, 32'h4000_9000, 32'h4000_c000,
        32'h4000_d000, 32'h4000_e000,
        32'h4002_0000, 32'h4002_0800, 32'h4002_1000, 32'h4002_1800,
        32'h4002_4000, 32'h4002_5000, 32'h4002_6000, 32'h4002_7000,
        32'h4002_8000, 32'h4002_c000, 32'h4002_d000,
        32'h4003_0000, 32'h4003_1000, 32'h4003_2000, 32'h4003_3000,
        32'h4003_8000, 32'h4003_c000, 32'h4004_0000, 32'h4004_1000,
        32'h400f_c000, 32'h400f_d000, 32'h400f_e000,
        32'he000_0000, 32'he000_1000, 32'he000_2000, 32'he000_e000,
        32'he004_0000
    };
    localparam logic [4:0] TGT_LOG [N_TGT] = '{
        5'h12, 5'h10,
        5'h0c, 5'h0c, 5'h0c, 5'h0c, 5'h0c, 5'h0c, 5'h0c, 5'h0c,
        5'h0c, 5'h0c,
        5'h0b, 5'h0b, 5'h0b, 5'h0b,
        5'h0c, 5'h0c, 5'h0c, 5'h0c, 5'h0c, 5'h0c, 5'h0c,
        5'h0c, 5'h0c, 5'h0c, 5'h0c,
        5'h0c, 5'h0c, 5'h0c, 5'h0c,
        5'h0c, 5'h0c, 5'h0c,
        5'h0c, 5'h0c, 5'h0c, 5'h0c,
        5'h0c
    };

    // Reset values
    localparam logic [N_TGT-1:0] SEL_RST  = '0;
    localparam logic [31:0]      WORD_RST = 32'h0000_0000;

    typedef enum {
        SAD_IDLE,
        SAD_ACCESS,
        SAD_WBACK,
        SAD_RESP
    } sad_state_e;

    // Master request and answer
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } sad_mreq_s;

    typedef struct packed {
        logic        valid;
        logic        fault;
        logic [31:0] rdata;
    } sad_mrsp_s;

    // Request to the selected slave and its shared answer
    typedef struct packed {
        logic [N_TGT-1:0] sel;
        logic             write;
        logic [17:0]      offset;
        logic [31:0]      wdata;
    } sad_sreq_s;

    typedef struct packed {
        logic        ready;
        logic [31:0] rdata;
    } sad_srsp_s;

    // Whole state of the decoder
    typedef struct packed {
        sad_state_e  st;
        sad_sreq_s   sreq;
        logic        alias_acc;
        logic        alias_wr;
        logic        alias_bit;
        logic [4:0]  pos;
        sad_mrsp_s   mrsp;
    } sad_reg_s;

endpackage

//--- logic/sad_decoder.sv
// System address decoder with bit-level alias handling
`timescale 1ns/1ps
module sad_decoder (
    // Clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              resetn_i,
    // Master side
    input  wire sad_pkg::sad_mreq_s mreq_i,
    output logic                    mreq_ready_o,
    output sad_pkg::sad_mrsp_s      mrsp_o,
    // Slave side
    output sad_pkg::sad_sreq_s      sreq_o,
    input  wire sad_pkg::sad_srsp_s srsp_i
);

    sad_pkg::sad_reg_s         q_r;
    sad_pkg::sad_reg_s         q_nxt;
    logic [31:0]               eff_addr;
    logic                      is_alias;
    logic [2:0]                alias_bitno;
    logic [sad_pkg::N_TGT-1:0] hit;
    logic [31:0]               off_mask;
    logic [31:0]               bit_mask;

    // Fold alias addresses onto the byte they stand for
    always_comb begin
        is_alias    = 1'b0;
        eff_addr    = mreq_i.addr;
        alias_bitno = mreq_i.addr[4:2];
        if (mreq_i.addr >= sad_pkg::SRAM_ALIAS_LO &&
            mreq_i.addr <= sad_pkg::SRAM_ALIAS_HI) begin
            is_alias = 1'b1;
            eff_addr = sad_pkg::SRAM_BASE
                     + ((mreq_i.addr & sad_pkg::ALIAS_OFF_MASK) >> 5);
        end else if (mreq_i.addr >= sad_pkg::PERI_ALIAS_LO &&
                     mreq_i.addr <= sad_pkg::PERI_ALIAS_HI) begin
            is_alias = 1'b1;
            eff_addr = sad_pkg::PERI_BASE
                     + ((mreq_i.addr & sad_pkg::ALIAS_OFF_MASK) >> 5);
        end
    end

    // One comparator per window; anything outside every window faults
    generate
        for (genvar i = 0; i < sad_pkg::N_TGT; i++) begin : g_win
            assign hit[i] = ((eff_addr ^ sad_pkg::TGT_BASE[i])
                             >> sad_pkg::TGT_LOG[i]) == 32'h0000_0000;
        end
    endgenerate

    // Offset mask of the hit window, so the slave sees only its own bits
    always_comb begin
        off_mask = 32'h0000_0000;
        for (int i = 0; i < sad_pkg::N_TGT; i++) begin
            if (hit[i]) begin
                off_mask = (32'h0000_0001 << sad_pkg::TGT_LOG[i]) - 32'h0000_0001;
            end
        end
    end

    assign bit_mask = 32'h0000_0001 << q_r.pos;

    // Next-state logic for the whole decoder
    always_comb begin
        q_nxt            = q_r;
        q_nxt.mrsp.valid = 1'b0;
        case (q_r.st)
            sad_pkg::SAD_IDLE: begin
                if (mreq_i.valid) begin
                    q_nxt.alias_acc = is_alias;
                    q_nxt.alias_wr  = is_alias & mreq_i.write;
                    q_nxt.alias_bit = mreq_i.wdata[0];
                    q_nxt.pos       = {eff_addr[1:0], alias_bitno};
                    if (hit == '0) begin
                        // Reserved, unfitted and vendor space all land here
                        q_nxt.mrsp.fault = 1'b1;
                        q_nxt.mrsp.rdata = sad_pkg::WORD_RST;
                        q_nxt.st         = sad_pkg::SAD_RESP;
                    end else begin
                        // Flash, SRAM, peripheral and private-bus windows
                        q_nxt.sreq.sel    = hit;
                        q_nxt.sreq.write  = mreq_i.write & ~is_alias;
                        q_nxt.sreq.offset = 18'((eff_addr & off_mask)
                                          & ~(is_alias ? 32'h0000_0003
                                                       : 32'h0000_0000));
                        q_nxt.sreq.wdata  = mreq_i.wdata;
                        q_nxt.mrsp.fault  = 1'b0;
                        q_nxt.st          = sad_pkg::SAD_ACCESS;
                    end
                end
            end
            sad_pkg::SAD_ACCESS: begin
                if (srsp_i.ready) begin
                    if (q_r.alias_wr) begin
                        // Alias write: read word first, then change one bit only
                        q_nxt.sreq.write = 1'b1;
                        q_nxt.sreq.wdata = q_r.alias_bit
                                         ? (srsp_i.rdata | bit_mask)
                                         : (srsp_i.rdata & ~bit_mask);
                        q_nxt.alias_wr   = 1'b0;
                        q_nxt.st         = sad_pkg::SAD_WBACK;
                    end else begin
                        q_nxt.sreq.sel   = sad_pkg::SEL_RST;
                        q_nxt.mrsp.rdata = q_r.alias_acc
                                         ? {31'h0000_0000, srsp_i.rdata[q_r.pos]}
                                         : srsp_i.rdata;
                        q_nxt.st         = sad_pkg::SAD_RESP;
                    end
                end
            end
            sad_pkg::SAD_WBACK: begin
                if (srsp_i.ready) begin
                    q_nxt.sreq.sel   = sad_pkg::SEL_RST;
                    q_nxt.sreq.write = 1'b0;
                    q_nxt.mrsp.rdata = sad_pkg::WORD_RST;
                    q_nxt.st         = sad_pkg::SAD_RESP;
                end
            end
            sad_pkg::SAD_RESP: begin
                // Answer stands one cycle, the same cycle in which the next request may come
                q_nxt.mrsp.valid = 1'b1;
                q_nxt.st         = sad_pkg::SAD_IDLE;
            end
            default: begin
                q_nxt.st       = sad_pkg::SAD_IDLE;
                q_nxt.sreq.sel = sad_pkg::SEL_RST;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q_r.st          <= sad_pkg::SAD_IDLE;
            q_r.sreq.sel    <= sad_pkg::SEL_RST;
            q_r.sreq.write  <= 1'b0;
            q_r.sreq.offset <= 18'h0_0000;
            q_r.sreq.wdata  <= sad_pkg::WORD_RST;
            q_r.alias_acc   <= 1'b0;
            q_r.alias_wr    <= 1'b0;
            q_r.alias_bit   <= 1'b0;
            q_r.pos         <= 5'h00;
            q_r.mrsp.valid  <= 1'b0;
            q_r.mrsp.fault  <= 1'b0;
            q_r.mrsp.rdata  <= sad_pkg::WORD_RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    // Ready only while idle, which keeps one access in flight at a time
    assign mreq_ready_o = (q_r.st == sad_pkg::SAD_IDLE);
    assign mrsp_o       = q_r.mrsp;
    assign sreq_o       = q_r.sreq;

endmodule // sad_decoder

//--- verif/sad_decoder_props.sv
// Port checker for the address decoder
`timescale 1ns/1ps
module sad_decoder_props (
    // Decoder ports
    input wire logic               ref_clk_i,
    input wire logic               resetn_i,
    input wire sad_pkg::sad_mreq_s mreq_i,
    input wire logic               mreq_ready_o,
    input wire sad_pkg::sad_mrsp_s mrsp_o,
    input wire sad_pkg::sad_sreq_s sreq_o,
    input wire sad_pkg::sad_srsp_s srsp_i
);
    wire [31:0] a = mreq_i.addr;
    wire [17:0] o = sreq_o.offset;
    wire [38:0] s = sreq_o.sel;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    // Taking edge, then a fault with no slave picked
    sequence s_tk(c); mreq_i.valid && mreq_ready_o && c; endsequence
    sequence s_flt; ##1 s == 39'h0 ##1 mrsp_o.valid && mrsp_o.fault; endsequence
    property p_rsv; s_tk(a inside {[32'h2010_0000:32'h21ff_ffff],
        [32'h2400_0000:32'h3fff_ffff]}) |-> s_flt; endproperty
    property p_vend; s_tk(a >= 32'he010_0000) |-> s_flt; endproperty
    property p_ppb; s_tk(a inside {[32'he000_3000:32'he000_dfff],
        [32'he000_f000:32'he003_ffff]}) |-> s_flt; endproperty
    // Routed accesses pick the right window; all but p_irqc also check the offset
    property p_fl; s_tk(a < 32'h4_0000) |=> s == 39'h1 && o == $past(a[17:0]); endproperty
    property p_sr; s_tk(a[31:16] == 16'h2000) |=> s == 39'h2
        && o == {2'h0, $past(a[15:0])}; endproperty
    property p_two; s_tk(a[31:12] == 20'h40020) |=> s[12 + $past(a[11])]
        && o == {7'h0, $past(a[10:0])}; endproperty
    property p_irqc; s_tk(a[31:12] == 20'he000e) |=> s[sad_pkg::TGT_IRQ_CTRL]; endproperty
    property p_al; s_tk(a[31:21] == 11'h110) |=> s == 39'h2
        && o == {2'h0, $past(a[20:7]), 2'h0}; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved SRAM not faulted");
    a_vend: assert property (p_vend) else $error("vendor space not faulted");
    a_ppb: assert property (p_ppb) else $error("private gap not faulted");
    a_fl: assert property (p_fl) else $error("flash route wrong");
    a_sr: assert property (p_sr) else $error("SRAM route wrong");
    a_two: assert property (p_two) else $error("two-wire half wrong");
    a_irqc: assert property (p_irqc) else $error("irq controller route wrong");
    a_al: assert property (p_al) else $error("SRAM alias word wrong");
endmodule // sad_decoder_props
bind sad_decoder sad_decoder_props u_sad_decoder_props (.ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i), .mreq_i(mreq_i), .mreq_ready_o(mreq_ready_o),
    .mrsp_o(mrsp_o), .sreq_o(sreq_o), .srsp_i(srsp_i));

//--- verif/sad_slave_model.sv
// Memory model standing behind every decoded window
`timescale 1ns/1ps
module sad_slave_model (
    // Clock and reset
    input  wire logic               ref_clk_i,
    input  wire logic               resetn_i,
    // Request, wait choice and answer
    input  wire sad_pkg::sad_sreq_s sreq_i,
    input  wire logic [1:0]         lat_i,
    output sad_pkg::sad_srsp_s      srsp_o
);
    logic [31:0] mem [int];
    logic [1:0]  cnt;
    int          k;
    // Answer after lat_i waits; a phase after a ready is a new access
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            srsp_o <= '0;
            cnt <= 2'h0;
        end else begin
            srsp_o.ready <= 1'b0;
            srsp_o.rdata <= ~srsp_o.rdata; // Idle data moves so stale reads show
            if (srsp_o.ready)
                cnt <= 2'h0;
            else if (sreq_i.sel != 39'h0 && cnt < lat_i)
                cnt <= cnt + 2'h1;
            else if (sreq_i.sel != 39'h0) begin
                for (int i = 0; i < sad_pkg::N_TGT; i++)
                    if (sreq_i.sel[i]) k = i * 32'h4_0000 + int'(sreq_i.offset);
                if (!mem.exists(k)) mem[k] = k * 32'h9e37_79b9;
                if (sreq_i.write) mem[k] = sreq_i.wdata;
                srsp_o.ready <= 1'b1;
                srsp_o.rdata <= mem[k];
            end
        end
    end
endmodule // sad_slave_model

//--- verif/sad_decoder_tb.sv
// Self-checking bench for the address decoder
`timescale 1ns/1ps
module sad_decoder_tb;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    sad_pkg::sad_mreq_s mreq = '0;
    logic rdy;
    sad_pkg::sad_mrsp_s mrsp;
    sad_pkg::sad_sreq_s sreq;
    sad_pkg::sad_srsp_s srsp;
    logic [1:0] lat = 2'h0;
    logic [31:0] mem [int];
    logic [31:0] r, t;
    int n_fail = 0;
    int num_checks = 0;
    int seed = 32'hb594;
    logic [31:0] dirs [20] = '{32'h0, 32'h3_fffc, 32'h4_0000, 32'h2000_fffc, 32'h2001_0000,
        32'h2010_0000, 32'h2220_0000, 32'h2400_0000, 32'h4000_1000, 32'h4002_07fc,
        32'h4002_0800, 32'h400f_f000, 32'h43ff_fffc, 32'he000_3000, 32'he000_e000,
        32'he000_f000, 32'he004_0ffc, 32'he004_1000, 32'he010_0000, 32'h5000_0000};
    // Clock at 200 MHz
    always #2.5 ref_clk_i = ~ref_clk_i;
    sad_decoder u_sad_decoder (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .mreq_i(mreq),
        .mreq_ready_o(rdy), .mrsp_o(mrsp), .sreq_o(sreq), .srsp_i(srsp));
    sad_slave_model u_sad_slave_model (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .sreq_i(sreq), .lat_i(lat), .srsp_o(srsp));
    // Counts, verdict and end of run
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Window holding a word, or -1 where nothing is fitted
    function automatic int find(logic [31:0] a);
        for (int i = 0; i < sad_pkg::N_TGT; i++)
            if (((a ^ sad_pkg::TGT_BASE[i]) >> sad_pkg::TGT_LOG[i]) == 0) return i;
        return -1;
    endfunction
    // One access, predicted from the map and the bench memory
    task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
        logic [31:0] b, ex, wd;
        logic al, fl;
        int i, k, p;
        al = a[31:25] == 7'h11 || a[31:25] == 7'h21;
        b = al ? (a[30] ? 32'h4000_0000 : 32'h2000_0000) + {12'h0, a[24:5]} : a;
        p = {b[1:0], a[4:2]};
        b[1:0] = 2'h0;
        i = find(b);
        fl = i < 0 || (al && (a[30] ? (i < 2 || i > 33) : i != 1));
        k = fl ? 0 : i * 32'h4_0000 + int'(b - sad_pkg::TGT_BASE[i]);
        wd = mem.exists(k) ? mem[k] : k * 32'h9e37_79b9;
        ex = 32'h0;
        if (!fl && w) mem[k] = al ? (wd & ~(32'h1 << p)) | ({31'h0, d[0]} << p) : d;
        if (!fl && !w) ex = al ? {31'h0, wd[p]} : wd;
        // A plain write answers with the word the slave hands back, which is the new word
        if (!fl && w && !al) ex = d;
        lat = 2'($random(seed));
        mreq = {1'b1, w, a, d};
        for (int n = 0; n < 40 && rdy !== 1'b1; n++) @(posedge ref_clk_i) #1;
        @(posedge ref_clk_i) #1 mreq.valid = 1'b0;
        for (int n = 0; n < 40 && mrsp.valid !== 1'b1; n++) @(posedge ref_clk_i) #1;
        num_checks++;
        if ({mrsp.valid, mrsp.fault, mrsp.rdata} !== {1'b1, fl, ex}) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time,
                {mrsp.valid, mrsp.fault, mrsp.rdata}, {1'b1, fl, ex});
        end
    endtask
    // Map edges, every window, then alias traffic with random waits
    initial begin
        repeat (6) @(posedge ref_clk_i);
        #1 resetn_i = 1'b1;
        foreach (dirs[j]) begin
            acc(1'b0, dirs[j], 32'h0);
            acc(1'b1, dirs[j], 32'h5a5a_a5a5);
        end
        for (int i = 0; i < sad_pkg::N_TGT; i++) begin
            r = $random(seed);
            t = sad_pkg::TGT_BASE[i] + (r & ((32'h1 << sad_pkg::TGT_LOG[i]) - 1) & ~32'h3);
            acc(1'b0, t, 32'h0);
            acc(1'b1, t, r);
            acc(1'b0, t, 32'h0);
        end
        repeat (60) begin
            r = $random(seed);
            t = r[0] ? 32'h2200_0000 + (r & 32'h1f_fffc) : 32'h4200_0000 + (r & 32'h1_fffc)
                + ((sad_pkg::TGT_BASE[2 + r[9:5]] - 32'h4000_0000) << 5);
            acc(1'b1, t, r >> 3);
            acc(1'b0, t, 32'h0);
            acc(1'b0, ((t[30] ? 32'h4000_0000 : 32'h2000_0000) + {12'h0, t[24:5]}) & ~32'h3,
                32'h0);
        end
        final_report();
    end
    // Watchdog for a hung handshake
    initial begin
        #100000;
        n_fail++;
        final_report();
    end
endmodule // sad_decoder_tb
